//--- verilog/msl_pkg.sv
// package: constants, register map and types of the mode switch and status led block
package msl_pkg;

   // ************************************************
   // timing
   // ************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int MS_NS = 1000000;
   localparam int WINDOW_MS = 5000;
   localparam int HOLD_MS = 500;
   localparam int LONG_PRESS_MS = 5000;
   localparam int DEBOUNCE_MS = 20;
   localparam int FAST_HALF_MS = 100;
   localparam int SLOW_HALF_MS = 500;
   localparam int CNT_W = 13;
   typedef logic [CNT_W-1:0] msl_cnt_t;
   // hold and long press times round up to whole ticks; window, debounce and blink times round down
   localparam msl_cnt_t WINDOW_TICKS = msl_cnt_t'((WINDOW_MS * (MS_NS / 1000)) / (TICK_NS / 1000));
   localparam msl_cnt_t HOLD_TICKS =
      msl_cnt_t'((HOLD_MS * (MS_NS / 1000) + TICK_NS / 1000 - 1) / (TICK_NS / 1000));
   localparam msl_cnt_t LONG_TICKS =
      msl_cnt_t'((LONG_PRESS_MS * (MS_NS / 1000) + TICK_NS / 1000 - 1) / (TICK_NS / 1000));
   localparam msl_cnt_t DEBOUNCE_TICKS = msl_cnt_t'((DEBOUNCE_MS * MS_NS) / TICK_NS);
   localparam msl_cnt_t FAST_TICKS = msl_cnt_t'((FAST_HALF_MS * MS_NS) / TICK_NS);
   localparam msl_cnt_t SLOW_TICKS = msl_cnt_t'((SLOW_HALF_MS * MS_NS) / TICK_NS);

   // ************************************************
   // register map
   // ************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FAULT = 8'h04;
   localparam logic [7:0] ADDR_HEALTH = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

   localparam int CTRL_W = 4;
   localparam int CTRL_MODE_SEL_BIT = 0;
   localparam int CTRL_MEM_PROT_BIT = 1;
   localparam int CTRL_P1_CONSOLE_BIT = 2;
   localparam int CTRL_SW_RUN_BIT = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h1;

   localparam int FAULT_W = 3;
   localparam int FLT_PLC_BIT = 0;
   localparam int FLT_IO_BIT = 1;
   localparam int FLT_NONFATAL_BIT = 2;
   localparam logic [FAULT_W-1:0] FAULT_RESET = 3'h0;

   localparam int HEALTH_W = 5;
   localparam int HL_PHASE_LO = 0;
   localparam int HL_BOOT_BIT = 2;
   localparam int HL_OVR_BIT = 3;
   localparam int HL_SCAN_BIT = 4;
   localparam logic [HEALTH_W-1:0] HEALTH_RESET = 5'h00;

   localparam int ST_MODE_LO = 0;
   localparam int ST_SWITCH_BIT = 2;
   localparam int ST_BUTTON_BIT = 3;
   localparam int ST_FORCED_BIT = 4;
   localparam int ST_FAULTED_BIT = 5;
   localparam int ST_BLOCK_BIT = 6;

   localparam int IRQ_W = 5;
   localparam int IRQ_SHORT_BIT = 0;
   localparam int IRQ_LONG_BIT = 1;
   localparam int IRQ_CLEARED_BIT = 2;
   localparam int IRQ_EXPIRED_BIT = 3;
   localparam int IRQ_RUN_BIT = 4;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

   typedef enum logic [1:0] {
      PH_DIAG = 2'h0,
      PH_CONFIG = 2'h1,
      PH_OK = 2'h2,
      PH_PROBLEM = 2'h3
   } msl_phase_e;

   // gray along stop -> window run -> window stop -> run
   typedef enum logic [1:0] {
      M_STOP = 2'b00,
      M_WIN_RUN = 2'b01,
      M_WIN_STOP = 2'b11,
      M_RUN = 2'b10
   } msl_mode_e;

   function automatic logic msl_addr_ok(input logic [7:0] a);
      msl_addr_ok = (a == ADDR_CTRL) || (a == ADDR_FAULT) || (a == ADDR_HEALTH) ||
                    (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
   endfunction : msl_addr_ok

endpackage : msl_pkg

//--- verilog/msl_time_if.sv
// interface: shared timebase tick and blink phases
`timescale 1ns/1ps
interface msl_time_if;
   logic tick;
   logic blink_fast;
   logic blink_slow;
   modport src (output tick, output blink_fast, output blink_slow);
   modport snk (input tick, input blink_fast, input blink_slow);
endinterface : msl_time_if

//--- verilog/msl_timebase.sv
// module: millisecond tick divider and blink phase generator
`timescale 1ns/1ps
module msl_timebase #(
   parameter int TICK_CYCLES_P = msl_pkg::TICK_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   msl_time_if.src tb
);
   import msl_pkg::*;

   typedef struct packed {
      logic [15:0] div;
      msl_cnt_t fast_cnt;
      msl_cnt_t slow_cnt;
      logic tick;
      logic fast;
      logic slow;
   } msl_tb_s;

   msl_tb_s r_reg;
   msl_tb_s r_next;

   always_comb begin
      r_next = r_reg;
      r_next.tick = 1'b0;
      if (r_reg.div == 16'(TICK_CYCLES_P - 1)) begin
         r_next.div = 16'h0000;
         r_next.tick = 1'b1;
      end else begin
         r_next.div = r_reg.div + 16'h0001;
      end
      if (r_reg.tick) begin
         if (r_reg.fast_cnt == FAST_TICKS - 1'b1) begin
            r_next.fast_cnt = '0;
            r_next.fast = ~r_reg.fast;
         end else begin
            r_next.fast_cnt = r_reg.fast_cnt + 1'b1;
         end
         if (r_reg.slow_cnt == SLOW_TICKS - 1'b1) begin
            r_next.slow_cnt = '0;
            r_next.slow = ~r_reg.slow;
         end else begin
            r_next.slow_cnt = r_reg.slow_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign tb.tick = r_reg.tick;
   assign tb.blink_fast = r_reg.fast;
   assign tb.blink_slow = r_reg.slow;

endmodule : msl_timebase

//--- verilog/msl_debounce.sv
// module: debounce of one front panel contact on the millisecond tick
`timescale 1ns/1ps
module msl_debounce (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic raw_in,
   msl_time_if.snk tb,
   output logic level_out
);
   import msl_pkg::*;

   typedef struct packed {
      logic level;
      msl_cnt_t cnt;
   } msl_deb_s;

   msl_deb_s r_reg;
   msl_deb_s r_next;

   // a new level must stand for the whole debounce time before it is taken
   always_comb begin
      r_next = r_reg;
      if (raw_in == r_reg.level) begin
         r_next.cnt = '0;
      end else if (tb.tick) begin
         if (r_reg.cnt >= DEBOUNCE_TICKS - 1'b1) begin
            r_next.level = raw_in;
            r_next.cnt = '0;
         end else begin
            r_next.cnt = r_reg.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign level_out = r_reg.level;

endmodule : msl_debounce

//--- verilog/msl_top.sv
// module: run/stop switch, restart pushbutton and status leds with apb registers
//
// Functional notes
// - run entry with non-fatal faults keeps faults
// - run entry while halted faulted starts blink window
// - run, stop, run holds clear faults, run
// - window expiry: led off, stay halted, keep faults
// - clearing procedure restartable from each run entry
// - mode select on, memory protect off by default
// - protect blocks memory writes and forcing by switch
// - short press restarts ethernet and tests its leds
// - long press toggles port one console forcing
// - power led follows 5v supply only
// - health led blinks diag fast, config slow
// - boot mode blinks health and green together
// - run led green run, amber scan stop
// - fault led on until both tables cleared
// - override led on while any override active
// - forcing persists; console configured port never toggles
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
module msl_top #(
   parameter int TICK_CYCLES_P = msl_pkg::TICK_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic mode_switch_in,
   input wire logic button_in,
   input wire logic power_5v_in,
   output logic power_led_out,
   output logic health_led_out,
   output logic run_green_out,
   output logic run_amber_out,
   output logic fault_led_out,
   output logic override_led_out,
   output logic run_mode_out,
   output logic fault_clear_out,
   output logic mem_write_block_out,
   output logic force_block_out,
   output logic eth_reset_out,
   output logic eth_led_test_out,
   output logic eth_fw_restart_out,
   output logic port1_console_out,
   output logic irq_out
);
   import msl_pkg::*;

   // ************************************************
   // timebase and debounced contacts
   // ************************************************
   msl_time_if tbus ();
   logic sw_db;
   logic btn_db;

   msl_timebase #(
      .TICK_CYCLES_P(TICK_CYCLES_P)
   ) u_timebase (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .tb(tbus)
   );

   msl_debounce u_deb_switch (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .raw_in(mode_switch_in),
      .tb(tbus),
      .level_out(sw_db)
   );

   msl_debounce u_deb_button (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .raw_in(button_in),
      .tb(tbus),
      .level_out(btn_db)
   );

   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      msl_mode_e mode;
      msl_cnt_t win_cnt;
      msl_cnt_t hold_cnt;
      msl_cnt_t btn_cnt;
      logic run_prev;
      logic btn_prev;
      logic forced;
      logic [CTRL_W-1:0] ctrl;
      logic [FAULT_W-1:0] fault;
      logic [HEALTH_W-1:0] health;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic power_led;
      logic health_led;
      logic run_green;
      logic run_amber;
      logic fault_led;
      logic override_led;
      logic run_mode;
      logic fault_clr;
      logic mem_block;
      logic eth_pulse;
      logic console;
      logic irq;
   } msl_top_s;

   msl_top_s r_reg;
   msl_top_s r_next;

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      logic [IRQ_W-1:0] ev;
      logic [IRQ_W-1:0] rdclr;
      logic faulted;
      logic run_pos;
      logic run_rise;
      logic in_window;
      logic apb_setup;
      logic apb_done;
      msl_phase_e phase;
      ev = '0;
      rdclr = '0;
      r_next = r_reg;
      r_next.fault_clr = 1'b0;
      r_next.eth_pulse = 1'b0;
      faulted = r_reg.fault[FLT_PLC_BIT] | r_reg.fault[FLT_IO_BIT];
      // switch selection off: software run bit stands in for it
      run_pos = r_reg.ctrl[CTRL_MODE_SEL_BIT] ? sw_db : r_reg.ctrl[CTRL_SW_RUN_BIT];
      run_rise = run_pos & ~r_reg.run_prev;
      r_next.run_prev = run_pos;
      apb_setup = psel_in & ~penable_in;
      apb_done = psel_in & penable_in & r_reg.pready;

      // mode switch sequence
      case (r_reg.mode)
         M_STOP: begin
            if (run_rise) begin
               r_next.win_cnt = '0;
               r_next.hold_cnt = '0;
               if (faulted) begin
                  r_next.mode = M_WIN_RUN;
               end else begin
                  r_next.mode = M_RUN;
                  ev[IRQ_RUN_BIT] = 1'b1;
               end
            end
         end
         M_RUN: begin
            if (!run_pos || faulted) begin
               r_next.mode = M_STOP;
            end
         end
         M_WIN_RUN: begin
            if (run_pos && tbus.tick && r_reg.hold_cnt != HOLD_TICKS) begin
               r_next.hold_cnt = r_reg.hold_cnt + 1'b1;
            end
            if (!run_pos) begin
               r_next.hold_cnt = '0;
               if (r_reg.hold_cnt >= HOLD_TICKS) begin
                  r_next.mode = M_WIN_STOP;
               end
            end
         end
         M_WIN_STOP: begin
            if (!run_pos && tbus.tick && r_reg.hold_cnt != HOLD_TICKS) begin
               r_next.hold_cnt = r_reg.hold_cnt + 1'b1;
            end
            if (run_pos) begin
               r_next.hold_cnt = '0;
               if (r_reg.hold_cnt >= HOLD_TICKS) begin
                  r_next.mode = M_RUN;
                  r_next.fault = '0;
                  r_next.fault_clr = 1'b1;
                  ev[IRQ_CLEARED_BIT] = 1'b1;
                  ev[IRQ_RUN_BIT] = 1'b1;
               end else begin
                  r_next.mode = M_WIN_RUN;
               end
            end
         end
         default: begin
            r_next.mode = M_STOP;
         end
      endcase

      in_window = (r_reg.mode == M_WIN_RUN) || (r_reg.mode == M_WIN_STOP);
      if (in_window && tbus.tick) begin
         r_next.win_cnt = r_reg.win_cnt + 1'b1;
      end
      // a completed sequence in the last tick still wins over expiry
      if (in_window && r_next.mode != M_RUN && r_reg.win_cnt >= WINDOW_TICKS) begin
         r_next.mode = M_STOP;
         ev[IRQ_EXPIRED_BIT] = 1'b1;
      end

      // restart pushbutton
      r_next.btn_prev = btn_db;
      if (btn_db && tbus.tick && r_reg.btn_cnt != LONG_TICKS) begin
         r_next.btn_cnt = r_reg.btn_cnt + 1'b1;
      end
      if (r_reg.btn_prev && !btn_db) begin
         r_next.btn_cnt = '0;
         if (r_reg.btn_cnt >= LONG_TICKS) begin
            ev[IRQ_LONG_BIT] = 1'b1;
            if (!r_reg.ctrl[CTRL_P1_CONSOLE_BIT]) begin
               r_next.forced = ~r_reg.forced;
            end
         end else begin
            r_next.eth_pulse = 1'b1;
            ev[IRQ_SHORT_BIT] = 1'b1;
         end
      end

      // apb slave: answer in the first access cycle
      r_next.pready = 1'b0;
      if (apb_setup) begin
         r_next.pready = 1'b1;
         r_next.pslverr = ~msl_addr_ok(paddr_in);
         r_next.prdata = 32'h0000_0000;
         case (paddr_in)
            ADDR_CTRL: r_next.prdata[CTRL_W-1:0] = r_reg.ctrl;
            ADDR_FAULT: r_next.prdata[FAULT_W-1:0] = r_reg.fault;
            ADDR_HEALTH: r_next.prdata[HEALTH_W-1:0] = r_reg.health;
            ADDR_STATUS: begin
               r_next.prdata[ST_MODE_LO +: 2] = r_reg.mode;
               r_next.prdata[ST_SWITCH_BIT] = sw_db;
               r_next.prdata[ST_BUTTON_BIT] = btn_db;
               r_next.prdata[ST_FORCED_BIT] = r_reg.forced;
               r_next.prdata[ST_FAULTED_BIT] = faulted;
               r_next.prdata[ST_BLOCK_BIT] = r_reg.mem_block;
            end
            ADDR_IRQ_STAT: r_next.prdata[IRQ_W-1:0] = r_reg.irq_stat;
            ADDR_IRQ_MASK: r_next.prdata[IRQ_W-1:0] = r_reg.irq_mask;
            default: r_next.prdata = 32'h0000_0000;
         endcase
      end
      if (apb_done && pwrite_in && msl_addr_ok(paddr_in)) begin
         // software write lands after the hardware clear and wins
         case (paddr_in)
            ADDR_CTRL: r_next.ctrl = pwdata_in[CTRL_W-1:0];
            ADDR_FAULT: r_next.fault = pwdata_in[FAULT_W-1:0];
            ADDR_HEALTH: r_next.health = pwdata_in[HEALTH_W-1:0];
            ADDR_IRQ_MASK: r_next.irq_mask = pwdata_in[IRQ_W-1:0];
            default: r_next.irq_mask = r_reg.irq_mask;
         endcase
      end
      // only the bits actually reported are cleared; a new event wins
      if (apb_done && !pwrite_in && paddr_in == ADDR_IRQ_STAT) begin
         rdclr = r_reg.prdata[IRQ_W-1:0];
      end
      r_next.irq_stat = (r_reg.irq_stat & ~rdclr) | ev;
      r_next.irq = |(r_next.irq_stat & r_next.irq_mask);

      // indicators
      phase = msl_phase_e'(r_reg.health[HL_PHASE_LO +: 2]);
      r_next.power_led = power_5v_in;
      r_next.fault_led = faulted;
      r_next.override_led = r_reg.health[HL_OVR_BIT];
      r_next.run_mode = (r_next.mode == M_RUN);
      r_next.mem_block = r_reg.ctrl[CTRL_MEM_PROT_BIT] & ~sw_db;
      r_next.console = r_next.ctrl[CTRL_P1_CONSOLE_BIT] | r_next.forced;
      if (r_reg.health[HL_BOOT_BIT]) begin
         r_next.health_led = tbus.blink_slow;
         r_next.run_green = tbus.blink_slow;
         r_next.run_amber = 1'b0;
      end else begin
         case (phase)
            PH_DIAG: r_next.health_led = tbus.blink_fast;
            PH_CONFIG: r_next.health_led = tbus.blink_slow;
            PH_OK: r_next.health_led = 1'b1;
            PH_PROBLEM: r_next.health_led = 1'b0;
            default: r_next.health_led = 1'b0;
         endcase
         r_next.run_green = (r_next.mode == M_RUN) ||
                            (((r_next.mode == M_WIN_RUN) || (r_next.mode == M_WIN_STOP)) &&
                             tbus.blink_fast);
         r_next.run_amber = (r_next.mode == M_STOP) && r_reg.health[HL_SCAN_BIT];
      end
   end

   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r_reg <= '0;
         r_reg.mode <= M_STOP;
         r_reg.ctrl <= CTRL_RESET;
         r_reg.fault <= FAULT_RESET;
         r_reg.health <= HEALTH_RESET;
         r_reg.irq_stat <= IRQ_RESET;
         r_reg.irq_mask <= IRQ_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata_out = r_reg.prdata;
   assign pready_out = r_reg.pready;
   assign pslverr_out = r_reg.pslverr;
   assign power_led_out = r_reg.power_led;
   assign health_led_out = r_reg.health_led;
   assign run_green_out = r_reg.run_green;
   assign run_amber_out = r_reg.run_amber;
   assign fault_led_out = r_reg.fault_led;
   assign override_led_out = r_reg.override_led;
   assign run_mode_out = r_reg.run_mode;
   assign fault_clear_out = r_reg.fault_clr;
   assign mem_write_block_out = r_reg.mem_block;
   assign force_block_out = r_reg.mem_block;
   // one pulse drives all three restart actions together
   assign eth_reset_out = r_reg.eth_pulse;
   assign eth_led_test_out = r_reg.eth_pulse;
   assign eth_fw_restart_out = r_reg.eth_pulse;
   assign port1_console_out = r_reg.console;
   assign irq_out = r_reg.irq;

endmodule : msl_top

//--- testbench/msl_asserts.sv
// checker: concurrent properties on the front panel block ports
`timescale 1ns/1ps
module msl_checker (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pready_out,
   input wire logic power_5v_in,
   input wire logic power_led_out,
   input wire logic mem_write_block_out,
   input wire logic force_block_out,
   input wire logic eth_reset_out,
   input wire logic eth_led_test_out,
   input wire logic eth_fw_restart_out,
   input wire logic fault_clear_out,
   input wire logic fault_led_out,
   input wire logic run_mode_out,
   input wire logic run_green_out,
   input wire logic run_amber_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   ready_after_setup_a: assert property ((psel_in && !penable_in) |=> pready_out)
      else $error("no ready after setup");
   ready_one_cycle_a: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   power_led_a: assert property (!$past(rst_in) |-> power_led_out == $past(power_5v_in))
      else $error("power led not following supply");
   block_pair_a: assert property (mem_write_block_out == force_block_out)
      else $error("write and force blocks differ");
   eth_pulse_a: assert property (eth_reset_out |->
      (eth_led_test_out && eth_fw_restart_out) ##1 !eth_reset_out)
      else $error("restart pulse malformed");
   clear_pulse_once_a: assert property (fault_clear_out |=> !fault_clear_out)
      else $error("clear pulse longer than one cycle");
   clear_to_run_a: assert property (fault_clear_out |-> ##[1:2] (run_mode_out && !fault_led_out))
      else $error("clear did not reach run");
   green_in_run_a: assert property ((run_mode_out && $past(run_mode_out)) |->
      (run_green_out && !run_amber_out))
      else $error("run led not green in run");
endmodule : msl_checker

//--- testbench/msl_operator.sv
// operator model: person moving the mode switch and pressing the pushbutton
`timescale 1ns/1ps
module msl_operator #(
   parameter int TICK_P = 2
) (
   input wire logic clk_in,
   output logic switch_out,
   output logic button_out
);
   initial begin
      switch_out = 1'b0;
      button_out = 1'b0;
   end
   // positions held in whole ms ticks; contact bounce is not modelled
   task automatic move_switch(input logic lvl, input int t);
      switch_out <= lvl;
      repeat (t * TICK_P) @(posedge clk_in);
   endtask : move_switch
   task automatic press(input int t);
      button_out <= 1'b1;
      repeat (t * TICK_P) @(posedge clk_in);
      button_out <= 1'b0;
      repeat (30 * TICK_P) @(posedge clk_in);
   endtask : press
endmodule : msl_operator

//--- testbench/testbench.sv
// testbench: apb driver and front panel scenarios for the mode switch block
`timescale 1ns/1ps
module testbench;
   import msl_pkg::*;
   localparam int TK = 2;
   logic clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, prdata_out;
   logic pready_out, pslverr_out, power_5v_in = 1'b1, sw, btn, power_led_out, health_led_out;
   logic run_green_out, run_amber_out, fault_led_out, override_led_out, run_mode_out;
   logic fault_clear_out, mem_write_block_out, force_block_out, eth_reset_out;
   logic eth_led_test_out, eth_fw_restart_out, port1_console_out, irq_out;
   int n_errors = 0, checks = 0, cyc = 0, n_eth = 0, th, tg, df, w;
   msl_top #(.TICK_CYCLES_P(TK)) dut (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .mode_switch_in(sw),
      .button_in(btn), .power_5v_in, .power_led_out, .health_led_out, .run_green_out,
      .run_amber_out, .fault_led_out, .override_led_out, .run_mode_out, .fault_clear_out,
      .mem_write_block_out, .force_block_out, .eth_reset_out, .eth_led_test_out,
      .eth_fw_restart_out, .port1_console_out, .irq_out);
   msl_operator #(.TICK_P(TK)) op (.clk_in(clk_in), .switch_out(sw), .button_out(btn));
   initial begin
      forever #50 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc++;
      if (eth_reset_out === 1'b1) n_eth++;
      if (cyc == 90000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : chk
   // ************************************************
   // apb master: held until ready is sampled high or 20 wait cycles pass
   // ************************************************
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk_in);
      end
      chk(n < 20, "apb ready timeout");
      r = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      // led stage settles
      repeat (2) @(posedge clk_in);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r === x && e === xe, $sformatf("read %h gave %h", a, r));
   endtask : rdc
   task automatic watch(input int n);
      logic ph, pg;
      th = 0;
      tg = 0;
      df = 0;
      ph = health_led_out;
      pg = run_green_out;
      repeat (n * TK) begin
         @(posedge clk_in);
         if (health_led_out !== ph) th++;
         if (run_green_out !== pg) tg++;
         if (health_led_out !== run_green_out) df++;
         ph = health_led_out;
         pg = run_green_out;
      end
   endtask : watch
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rdc(ADDR_CTRL, 32'h1, 1'b0);
      rdc(ADDR_FAULT, 32'h0, 1'b0);
      rdc(8'h18, 32'h0, 1'b1);
      chk(power_led_out === 1'b1, "power led off");
      power_5v_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      chk(power_led_out === 1'b0, "power led on");
      power_5v_in <= 1'b1;
      wr(ADDR_IRQ_MASK, 32'h1f);
      $display("test reset done");
      wr(ADDR_FAULT, 32'h4);
      op.move_switch(1'b1, 30);
      chk(run_mode_out === 1'b1 && run_green_out === 1'b1 && irq_out === 1'b1, "run");
      rdc(ADDR_FAULT, 32'h4, 1'b0);
      rdc(ADDR_STATUS, 32'h06, 1'b0);
      rdc(ADDR_IRQ_STAT, 32'h10, 1'b0);
      chk(irq_out === 1'b0, "irq stuck");
      wr(ADDR_CTRL, 32'h3);
      op.move_switch(1'b0, 30);
      chk(run_mode_out === 1'b0 && mem_write_block_out === 1'b1, "protect");
      rdc(ADDR_STATUS, 32'h40, 1'b0);
      wr(ADDR_CTRL, 32'h0);
      op.move_switch(1'b1, 30);
      chk(run_mode_out === 1'b0 && mem_write_block_out === 1'b0, "switch ignored");
      wr(ADDR_CTRL, 32'h8);
      chk(run_mode_out === 1'b1, "software run");
      wr(ADDR_CTRL, 32'h1);
      op.move_switch(1'b0, 30);
      chk(run_mode_out === 1'b0, "stop");
      rdc(ADDR_IRQ_STAT, 32'h10, 1'b0);
      $display("test modes done");
      wr(ADDR_FAULT, 32'h1);
      op.move_switch(1'b1, 30);
      chk(fault_led_out === 1'b1 && run_mode_out === 1'b0, "halted");
      rdc(ADDR_STATUS, 32'h25, 1'b0);
      watch(300);
      chk(tg >= 2, "window blink");
      op.move_switch(1'b1, 5000);
      rdc(ADDR_STATUS, 32'h24, 1'b0);
      rdc(ADDR_FAULT, 32'h1, 1'b0);
      chk(run_green_out === 1'b0 && fault_led_out === 1'b1, "expiry");
      rdc(ADDR_IRQ_STAT, 32'h08, 1'b0);
      op.move_switch(1'b0, 30);
      op.move_switch(1'b1, 30);
      rdc(ADDR_STATUS, 32'h25, 1'b0);
      op.move_switch(1'b1, 570);
      op.move_switch(1'b0, 600);
      op.move_switch(1'b1, 0);
      w = 0;
      while (fault_clear_out !== 1'b1 && w < 400) begin
         w++;
         @(posedge clk_in);
      end
      chk(w < 400, "no clear pulse");
      repeat (2) @(posedge clk_in);
      chk(run_mode_out === 1'b1 && fault_led_out === 1'b0 && run_green_out === 1'b1, "clr");
      rdc(ADDR_FAULT, 32'h0, 1'b0);
      rdc(ADDR_IRQ_STAT, 32'h14, 1'b0);
      op.move_switch(1'b0, 30);
      $display("test fault clear done");
      op.press(100);
      chk(n_eth == 1 && port1_console_out === 1'b0, "short press");
      rdc(ADDR_IRQ_STAT, 32'h01, 1'b0);
      op.press(5050);
      chk(n_eth == 1 && port1_console_out === 1'b1, "long press");
      rdc(ADDR_IRQ_STAT, 32'h02, 1'b0);
      rdc(ADDR_STATUS, 32'h10, 1'b0);
      op.press(5050);
      chk(port1_console_out === 1'b0, "toggle back");
      wr(ADDR_CTRL, 32'h5);
      op.press(5050);
      chk(port1_console_out === 1'b1 && n_eth == 1, "console port");
      rdc(ADDR_STATUS, 32'h00, 1'b0);
      wr(ADDR_CTRL, 32'h1);
      $display("test button done");
      wr(ADDR_HEALTH, 32'h0);
      watch(500);
      chk(th >= 4 && th <= 6, "fast blink");
      wr(ADDR_HEALTH, 32'h1);
      watch(1100);
      chk(th >= 1 && th <= 3, "slow blink");
      wr(ADDR_HEALTH, 32'h3);
      chk(health_led_out === 1'b0, "problem");
      wr(ADDR_HEALTH, 32'h6);
      watch(1100);
      chk(df == 0 && th >= 1 && run_amber_out === 1'b0, "boot blink");
      wr(ADDR_HEALTH, 32'h1a);
      chk(run_amber_out === 1'b1 && run_green_out === 1'b0, "scan stop");
      chk(override_led_out === 1'b1 && health_led_out === 1'b1, "override");
      wr(ADDR_HEALTH, 32'h2);
      chk(run_amber_out === 1'b0 && override_led_out === 1'b0, "no scan");
      $display("test leds done");
      final_report();
   end
endmodule : testbench
bind msl_top msl_checker chk_i (.clk_in, .rst_in, .psel_in, .penable_in, .pready_out,
   .power_5v_in, .power_led_out, .mem_write_block_out, .force_block_out, .eth_reset_out,
   .eth_led_test_out, .eth_fw_restart_out, .fault_clear_out, .fault_led_out, .run_mode_out,
   .run_green_out, .run_amber_out);
